// ==== match_based_pwm_timer.sv ====
//Function
//- thirty-two bit counter behind a programmable thirty-two bit prescaler is the time base
//- counter counts clock in timer mode or edges of a chosen capture input
//- seven match registers serve six single-edge or three double-edge outputs
//- cycle match resets the count and sets the shared period
//- single-edge outputs rise at each cycle start unless held constantly low
//- each single-edge output has one match register setting its falling edge
//- each double-edge output has separate rising and falling match registers
//- rising before falling gives positive pulse, otherwise negative pulse
//- period and width are whole counts, one repetition rate for all
//- each match may continue, reset or stop the counter, optionally flagging
//- in modulation mode new match values act only after release and only at cycle boundary
//- with modulation off the block is a plain timer, outputs low
`timescale 1ns/10ps
module match_based_pwm_timer
   import pwm_timer_pkg::*;
(
   input  wire logic                 CLOCK_I,
   input  wire logic                 RST_I,
   input  wire logic [6:0]           AVS_ADDRESS_I,
   input  wire logic                 AVS_READ_I,
   input  wire logic                 AVS_WRITE_I,
   input  wire logic [31:0]          AVS_WRITEDATA_I,
   input  wire logic [3:0]           AVS_BYTEENABLE_I,
   output wire logic [31:0]          AVS_READDATA_O,
   output wire logic                 AVS_WAITREQUEST_O,
   input  wire logic [1:0]           CAP_I,
   output wire logic [NUM_MATCH-1:1] PWM_O,
   output wire logic                 MATCH_IRQ_O
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [CTRL_W-1:0]          ctrl;
   logic [CTRL_W-1:0]          next_ctrl;
   logic [31:0]                tc;
   logic [31:0]                next_tc;
   logic [31:0]                pr;
   logic [31:0]                next_pr;
   logic [31:0]                pc;
   logic [31:0]                next_pc;
   src_t                       src;
   src_t                       next_src;
   logic                       cap_sel;
   logic                       next_cap_sel;
   logic [NUM_MATCH*ACT_W-1:0] mact;
   logic [NUM_MATCH*ACT_W-1:0] next_mact;
   logic [NUM_MATCH-1:0]       flags;
   logic [NUM_MATCH-1:0]       next_flags;
   logic [NUM_MATCH-1:0]       rel;
   logic [NUM_MATCH-1:0]       next_rel;
   logic [OUTCFG_W-1:0]        outcfg;
   logic [OUTCFG_W-1:0]        next_outcfg;
   logic [31:0]                shadow [NUM_MATCH];
   logic [31:0]                next_shadow [NUM_MATCH];
   logic [31:0]                active [NUM_MATCH];
   logic [31:0]                next_active [NUM_MATCH];
   logic                       waitreq;
   logic                       next_waitreq;
   logic [31:0]                rdata;
   logic [31:0]                next_rdata;
   logic                       irq;
   logic                       next_irq;
   logic [1:0]                 cap_s1;
   logic [1:0]                 cap_s2;
   logic [1:0]                 cap_s3;

   // helpers
   logic                       edge_seen;
   logic                       tick;
   logic                       wrap;
   logic                       stop_hit;
   logic                       wr_take;
   logic                       rd_take;
   logic                       is_match;
   logic [2:0]                 midx;
   logic [31:0]                wm;
   logic [31:0]                wd;
   logic [31:0]                rd_word;
   logic [NUM_MATCH-1:0]       hit;
   logic [NUM_MATCH-1:0]       zero;

   // one action bit of every channel, gathered into a mask
   function automatic logic [NUM_MATCH-1:0] mask_of(input logic [NUM_MATCH*ACT_W-1:0] act, input int pos);
      for (int i = 0; i < NUM_MATCH; i++) begin
         mask_of[i] = act[i*ACT_W+pos];
      end
   endfunction

   assign AVS_READDATA_O    = rdata;
   assign AVS_WAITREQUEST_O = waitreq;
   assign MATCH_IRQ_O       = irq;

   ////////////////////////////////////////////////////////////////////////////
   // output shaping unit
   pwm_edge_if eif ();

   assign eif.hit    = hit;
   assign eif.wrap   = wrap;
   assign eif.pwm_on = ctrl[CTRL_PWM];
   assign eif.dual   = outcfg[NUM_MATCH-1:0];
   assign eif.oe     = outcfg[OUT_EN+:NUM_MATCH];
   assign eif.zero   = zero;
   assign PWM_O      = eif.pwm;

   pwm_edge_unit u_edge (
      .clk_i (CLOCK_I),
      .rst_i (RST_I),
      .eb    (eif)
   );

   ////////////////////////////////////////////////////////////////////////////
   // capture input synchroniser, three stages
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         cap_s1 <= 2'h0;
         cap_s2 <= 2'h0;
         cap_s3 <= 2'h0;
      end else begin
         cap_s1 <= CAP_I;
         cap_s2 <= cap_s1;
         cap_s3 <= cap_s2;
      end
   end

   // edge once stage two holds the new level while stage three still holds the old
   always_comb begin
      unique case (src)
         SRC_TIMER: edge_seen = 1'b0;
         SRC_RISE:  edge_seen = cap_s2[cap_sel] & ~cap_s3[cap_sel];
         SRC_FALL:  edge_seen = ~cap_s2[cap_sel] & cap_s3[cap_sel];
         SRC_BOTH:  edge_seen = cap_s2[cap_sel] ^ cap_s3[cap_sel];
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // count tick and match compare
   assign tick = ctrl[CTRL_RUN] & ((src == SRC_TIMER) ? (pc == pr) : edge_seen);

   generate
      for (genvar g = 0; g < NUM_MATCH; g++) begin : g_cmp
         assign hit[g]  = tick & (tc == active[g]);
         assign zero[g] = (active[g] == RST_WORD);
      end
   endgenerate

   // cycle match always restarts the count in modulation mode
   assign wrap     = |(hit & mask_of(mact, ACT_RST)) | (ctrl[CTRL_PWM] & hit[0]);
   assign stop_hit = |(hit & mask_of(mact, ACT_STOP));

   ////////////////////////////////////////////////////////////////////////////
   // bus decode: one wait cycle, answer on the following edge
   assign wr_take  = AVS_WRITE_I & ~waitreq;
   assign rd_take  = AVS_READ_I & waitreq;
   assign is_match = (AVS_ADDRESS_I[6:5] == OFS_MATCH[6:5]) && (AVS_ADDRESS_I[4:2] != 3'h7);
   assign midx     = AVS_ADDRESS_I[4:2];

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wm[8*b+:8] = {8{AVS_BYTEENABLE_I[b]}};
      end
      wd = AVS_WRITEDATA_I & wm;
   end

   // read mux, unmapped reads return zero
   always_comb begin
      rd_word = RST_WORD;
      unique case ({AVS_ADDRESS_I[6:2], 2'h0})
         OFS_CTRL:    rd_word = {29'h0, ctrl};
         OFS_COUNT:   rd_word = tc;
         OFS_PRE_LIM: rd_word = pr;
         OFS_PRE_CNT: rd_word = pc;
         OFS_SRC:     rd_word = {29'h0, cap_sel, src};
         OFS_MACT:    rd_word = {11'h0, mact};
         OFS_FLAGS:   rd_word = {25'h0, flags};
         OFS_OUTCFG:  rd_word = {16'h0, outcfg};
         OFS_RELEASE: rd_word = {25'h0, rel};
         OFS_PWMSTAT: rd_word = {25'h0, eif.pwm, 1'b0};
         default: begin
            if (is_match) begin
               rd_word = shadow[midx];
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state of timer, registers and bus answer
   always_comb begin
      next_ctrl    = ctrl;
      next_tc      = tc;
      next_pr      = pr;
      next_pc      = pc;
      next_src     = src;
      next_cap_sel = cap_sel;
      next_mact    = mact;
      next_flags   = flags;
      next_rel     = rel;
      next_outcfg  = outcfg;
      next_shadow  = shadow;
      next_active  = active;
      next_rdata   = rdata;
      next_waitreq = ~((AVS_READ_I | AVS_WRITE_I) & waitreq);

      // prescaler and counter
      if (ctrl[CTRL_RUN] && (src == SRC_TIMER)) begin
         next_pc = (pc == pr) ? RST_WORD : pc + 32'h0000_0001;
      end
      if (wrap) begin
         next_tc = RST_WORD;
      end else if (tick) begin
         next_tc = tc + 32'h0000_0001;
      end
      if (ctrl[CTRL_CLR]) begin
         next_tc = RST_WORD;
         next_pc = RST_WORD;
      end
      if (stop_hit) begin
         next_ctrl[CTRL_RUN] = 1'b0;
      end

      // released shadows load at the cycle boundary
      for (int i = 0; i < NUM_MATCH; i++) begin
         if (wrap && rel[i]) begin
            if (ctrl[CTRL_PWM]) begin
               next_active[i] = shadow[i];
            end
            next_rel[i] = 1'b0;
         end
      end

      // software writes; release bits set here win over the clear above
      if (wr_take) begin
         unique case ({AVS_ADDRESS_I[6:2], 2'h0})
            OFS_CTRL:    next_ctrl = (ctrl & ~wm[CTRL_W-1:0]) | wd[CTRL_W-1:0];
            OFS_COUNT:   next_tc = (tc & ~wm) | wd;
            OFS_PRE_LIM: next_pr = (pr & ~wm) | wd;
            OFS_PRE_CNT: next_pc = (pc & ~wm) | wd;
            OFS_SRC: begin
               if (AVS_BYTEENABLE_I[0]) begin
                  next_src     = src_t'(AVS_WRITEDATA_I[1:0]);
                  next_cap_sel = AVS_WRITEDATA_I[SRC_CAP];
               end
            end
            OFS_MACT:    next_mact = (mact & ~wm[NUM_MATCH*ACT_W-1:0]) | wd[NUM_MATCH*ACT_W-1:0];
            OFS_FLAGS:   next_flags = flags & ~wd[NUM_MATCH-1:0];
            OFS_OUTCFG:  next_outcfg = (outcfg & ~wm[OUTCFG_W-1:0]) | wd[OUTCFG_W-1:0];
            OFS_RELEASE: next_rel = next_rel | wd[NUM_MATCH-1:0];
            default: begin
               if (is_match) begin
                  next_shadow[midx] = (shadow[midx] & ~wm) | wd;
                  // plain timer mode takes new values at once
                  if (!ctrl[CTRL_PWM]) begin
                     next_active[midx] = (shadow[midx] & ~wm) | wd;
                  end
               end
            end
         endcase
      end

      // match flags: a new event wins over a clear in the same cycle
      next_flags = next_flags | (hit & mask_of(mact, ACT_INT));
      next_irq   = |next_flags;

      if (rd_take) begin
         next_rdata = rd_word;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         ctrl    <= '0;
         tc      <= RST_WORD;
         pr      <= RST_WORD;
         pc      <= RST_WORD;
         src     <= SRC_TIMER;
         cap_sel <= 1'b0;
         mact    <= '0;
         flags   <= '0;
         rel     <= '0;
         outcfg  <= '0;
         for (int i = 0; i < NUM_MATCH; i++) begin
            shadow[i] <= RST_WORD;
            active[i] <= RST_WORD;
         end
         waitreq <= 1'b1;
         rdata   <= RST_WORD;
         irq     <= 1'b0;
      end else begin
         ctrl    <= next_ctrl;
         tc      <= next_tc;
         pr      <= next_pr;
         pc      <= next_pc;
         src     <= next_src;
         cap_sel <= next_cap_sel;
         mact    <= next_mact;
         flags   <= next_flags;
         rel     <= next_rel;
         outcfg  <= next_outcfg;
         shadow  <= next_shadow;
         active  <= next_active;
         waitreq <= next_waitreq;
         rdata   <= next_rdata;
         irq     <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_wrap_zero;
      @(posedge CLOCK_I) disable iff (RST_I)
      (ctrl[CTRL_PWM] && hit[0] && !wr_take) |=> (tc == RST_WORD);
   endproperty
   a_wrap_zero: assert property (p_wrap_zero) else $error("cycle match did not restart count");

   property p_prescale;
      @(posedge CLOCK_I) disable iff (RST_I)
      (ctrl[CTRL_RUN] && (src == SRC_TIMER) && (pc != pr) && !wr_take && !ctrl[CTRL_CLR])
         |=> ((pc == $past(pc) + 32'h0000_0001) && $stable(tc));
   endproperty
   a_prescale: assert property (p_prescale) else $error("prescaler step or hold wrong");

   property p_release;
      @(posedge CLOCK_I) disable iff (RST_I)
      (ctrl[CTRL_PWM] && wrap && rel[1] && !wr_take) |=> ((active[1] == $past(shadow[1])) && !rel[1]);
   endproperty
   a_release: assert property (p_release) else $error("released value not loaded at wrap");

   property p_hold;
      @(posedge CLOCK_I) disable iff (RST_I)
      (ctrl[CTRL_PWM] && !wrap) |=> $stable(active[1]);
   endproperty
   a_hold: assert property (p_hold) else $error("active compare changed inside a cycle");

   property p_stop;
      @(posedge CLOCK_I) disable iff (RST_I)
      (stop_hit && !wr_take) |=> !ctrl[CTRL_RUN] ##1 ($stable(tc) || $past(wr_take));
   endproperty
   a_stop: assert property (p_stop) else $error("stop on match did not halt counter");

   property p_counter_mode;
      @(posedge CLOCK_I) disable iff (RST_I)
      ((src != SRC_TIMER) && !edge_seen && !wr_take && !ctrl[CTRL_CLR]) |=> $stable(tc);
   endproperty
   a_counter_mode: assert property (p_counter_mode) else $error("counter moved without input edge");

endmodule // match_based_pwm_timer

// ==== pwm_timer_pkg.sv ====
package pwm_timer_pkg;

   // match channels: 0 is the cycle match, 1..6 drive outputs
   localparam int NUM_MATCH = 7;

   // register byte offsets
   localparam logic [6:0] OFS_CTRL    = 7'h00;
   localparam logic [6:0] OFS_COUNT   = 7'h04;
   localparam logic [6:0] OFS_PRE_LIM = 7'h08;
   localparam logic [6:0] OFS_PRE_CNT = 7'h0C;
   localparam logic [6:0] OFS_SRC     = 7'h10;
   localparam logic [6:0] OFS_MACT    = 7'h14;
   localparam logic [6:0] OFS_FLAGS   = 7'h18;
   localparam logic [6:0] OFS_OUTCFG  = 7'h1C;
   localparam logic [6:0] OFS_RELEASE = 7'h20;
   localparam logic [6:0] OFS_PWMSTAT = 7'h24;
   localparam logic [6:0] OFS_MATCH   = 7'h40;

   // control bits
   localparam int CTRL_W   = 3;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_CLR = 1;
   localparam int CTRL_PWM = 2;

   // source register: [1:0] count source, [2] capture input select
   localparam int SRC_CAP = 2;

   // per-match action field, ACT_W bits per channel
   localparam int ACT_W    = 3;
   localparam int ACT_INT  = 0;
   localparam int ACT_RST  = 1;
   localparam int ACT_STOP = 2;

   // output config: [6:0] double-edge select, [14:8] output enable
   localparam int OUTCFG_W = 16;
   localparam int OUT_EN   = 8;

   // reset value of every register
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   typedef enum logic [1:0] {
      SRC_TIMER = 2'h0,
      SRC_RISE  = 2'h1,
      SRC_FALL  = 2'h2,
      SRC_BOTH  = 2'h3
   } src_t;

endpackage

// ==== pwm_edge_if.sv ====
`timescale 1ns/10ps
interface pwm_edge_if
   import pwm_timer_pkg::*;
();
   logic [NUM_MATCH-1:0] hit;
   logic                 wrap;
   logic                 pwm_on;
   logic [NUM_MATCH-1:0] dual;
   logic [NUM_MATCH-1:0] oe;
   logic [NUM_MATCH-1:0] zero;
   logic [NUM_MATCH-1:1] pwm;

   modport driver (output hit, output wrap, output pwm_on, output dual, output oe, output zero, input pwm);
   modport shaper (input hit, input wrap, input pwm_on, input dual, input oe, input zero, output pwm);
endinterface

// ==== pwm_edge_unit.sv ====
`timescale 1ns/10ps
module pwm_edge_unit
   import pwm_timer_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   pwm_edge_if.shaper eb
);

   logic [NUM_MATCH-1:1] pwm_q;
   logic [NUM_MATCH-1:1] next_pwm;

   assign eb.pwm = pwm_q;

   ////////////////////////////////////////////////////////////////////////////
   // set and clear each output from the match events
   always_comb begin
      next_pwm = pwm_q;
      for (int n = 1; n < NUM_MATCH; n++) begin
         if (!eb.pwm_on || !eb.oe[n]) begin
            next_pwm[n] = 1'b0;
         end else if (eb.hit[n]) begin
            next_pwm[n] = 1'b0;
         end else if ((n > 1) && eb.dual[n]) begin
            if (eb.hit[n-1]) begin
               next_pwm[n] = 1'b1;
            end
         end else if (eb.wrap && !eb.zero[n]) begin
            next_pwm[n] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwm_q <= '0;
      end else begin
         pwm_q <= next_pwm;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_pwm_off;
      @(posedge clk_i) disable iff (rst_i)
      !eb.pwm_on |=> (pwm_q == '0);
   endproperty
   a_pwm_off: assert property (p_pwm_off) else $error("output active with modulation off");

   property p_single_rise;
      @(posedge clk_i) disable iff (rst_i)
      (eb.pwm_on && eb.oe[1] && eb.wrap && !eb.zero[1] && !eb.hit[1]) |=> pwm_q[1];
   endproperty
   a_single_rise: assert property (p_single_rise) else $error("single edge output not set at cycle start");

   property p_dual_edges;
      @(posedge clk_i) disable iff (rst_i)
      (eb.pwm_on && eb.oe[2] && eb.dual[2] && eb.hit[1] && !eb.hit[2]) |=> pwm_q[2]
         ##1 (pwm_q[2] || $past(eb.hit[2]) || !$past(eb.oe[2]) || !$past(eb.pwm_on));
   endproperty
   a_dual_edges: assert property (p_dual_edges) else $error("double edge output missed its rising match");

endmodule // pwm_edge_unit

// ==== pwm_load_model.sv ====
`timescale 1ns/10ps
module pwm_load_model
   import pwm_timer_pkg::*;
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic [NUM_MATCH-1:1] pwm_i
);

   logic [NUM_MATCH-1:1] prev;
   logic [15:0]          hi_run  [1:6];
   logic [15:0]          per_run [1:6];
   logic [15:0]          hi_len  [1:6];
   logic [15:0]          per_len [1:6];

   ////////////////////////////////////////////////////////////////////////////////
   // load side: measures high time and rise-to-rise period of every drive line
   always_ff @(posedge clk_i) begin
      prev <= rst_i ? '0 : pwm_i;
      for (int n = 1; n < NUM_MATCH; n++) begin
         if (rst_i) begin
            hi_run[n]  <= 16'h0000;
            per_run[n] <= 16'h0000;
            hi_len[n]  <= 16'h0000;
            per_len[n] <= 16'h0000;
         end else begin
            // whole clock counts, one period per line
            if (pwm_i[n] && !prev[n]) begin
               per_len[n] <= per_run[n];
               per_run[n] <= 16'h0001;
            end else begin
               per_run[n] <= per_run[n] + 16'h0001;
            end
            // high run restarts on each rise, latched on the fall
            if (pwm_i[n]) begin
               hi_run[n] <= prev[n] ? hi_run[n] + 16'h0001 : 16'h0001;
            end
            if (!pwm_i[n] && prev[n]) begin
               hi_len[n] <= hi_run[n];
            end
         end
      end
   end

endmodule // pwm_load_model

// ==== match_based_pwm_timer_bench.sv ====
`timescale 1ns/10ps
module match_based_pwm_timer_bench
   import pwm_timer_pkg::*;
;

   localparam int lim     = 1;
   localparam int per_m   = 9;
   localparam int m1      = 3;
   localparam int m2      = 6;
   localparam int m3      = 8;
   localparam int m4      = 4;
   localparam int per_clk = (per_m + 1) * (lim + 1);

   logic                 clk;
   logic                 rst;
   logic                 rd_en;
   logic                 wr_en;
   logic [6:0]           adr;
   logic [31:0]          wdat;
   logic [31:0]          rdata;
   logic [31:0]          seen;
   logic [3:0]           be;
   logic [1:0]           cap;
   logic [NUM_MATCH-1:1] pwm;
   logic                 wreq;
   logic                 irq;
   int                   n_mismatch;
   int                   samples_checked;

   match_based_pwm_timer DUT (
      .CLOCK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en),
      .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
      .AVS_WAITREQUEST_O(wreq), .CAP_I(cap), .PWM_O(pwm), .MATCH_IRQ_O(irq)
   );

   pwm_load_model load (.clk_i(clk), .rst_i(rst), .pwm_i(pwm));

   ////////////////////////////////////////////////////////////////////////////////
   // reporting
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // avalon master: hold request until waitrequest seen low at a rising edge
   task automatic access(input logic w, input logic [6:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      adr   <= a;
      wdat  <= d;
      wr_en <= w;
      rd_en <= !w;
      // waitrequest and read data sampled at the rising edge only
      for (i = 0; i < 40; i++) begin
         @(posedge clk);
         if (wreq === 1'b0) break;
      end
      if (i == 40) begin
         n_mismatch++;
         test_done();
      end
      seen = rdata;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
   endtask

   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      access(1'b1, a, d);
   endtask

   task automatic rd_chk(input string what, input logic [6:0] a, input logic [31:0] exp);
      access(1'b0, a, 32'h0000_0000);
      check(what, seen, exp);
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      rd_chk("ctrl", OFS_CTRL, 32'h0000_0000);
      rd_chk("count", OFS_COUNT, 32'h0000_0000);
      rd_chk("unmapped", 7'h7C, 32'h0000_0000);
      check("pwm idle", 32'(pwm), 32'h0000_0000);
      check("irq idle", 32'(irq), 32'h0000_0000);
      $display("test reset done");
   endtask

   task automatic t_count_mode();
      int m;
      int k;
      for (m = 1; m < 5; m++) begin
         wr(OFS_CTRL, 32'h0000_0000);
         wr(OFS_COUNT, 32'h0000_0000);
         // pass four counts rising edges of input 1
         wr(OFS_SRC, (m == 4) ? 32'h0000_0005 : 32'(m));
         wr(OFS_CTRL, 32'h0000_0001);
         // three pulses on input 0, one on input 1
         for (k = 0; k < 3; k++) begin
            @(posedge clk);
            cap <= 2'b01;
            wait_clk(4);
            cap <= 2'b00;
            wait_clk(4);
         end
         cap <= 2'b10;
         wait_clk(4);
         cap <= 2'b00;
         wait_clk(8);
         rd_chk("edge count", OFS_COUNT, (m == 3) ? 32'h0000_0006 : ((m == 4) ? 32'h0000_0001 : 32'h0000_0003));
      end
      $display("test counter mode done");
   endtask

   task automatic t_actions();
      wr(OFS_CTRL, 32'h0000_0000);
      wr(OFS_SRC, 32'h0000_0000);
      wr(OFS_COUNT, 32'h0000_0000);
      wr(OFS_MACT, 32'h0000_0028);
      wr(OFS_MATCH + 7'h04, 32'h0000_0005);
      wr(OFS_CTRL, 32'h0000_0001);
      wait_clk(20);
      rd_chk("stop count", OFS_COUNT, 32'h0000_0006);
      rd_chk("stop run", OFS_CTRL, 32'h0000_0000);
      rd_chk("flags", OFS_FLAGS, 32'h0000_0002);
      check("irq", 32'(irq), 32'h0000_0001);
      wr(OFS_FLAGS, 32'h0000_0002);
      wait_clk(2);
      check("irq clear", 32'(irq), 32'h0000_0000);
      wr(OFS_CTRL, 32'h0000_0002);
      rd_chk("clear count", OFS_COUNT, 32'h0000_0000);
      wr(OFS_MACT, 32'h0000_0018);
      wr(OFS_COUNT, 32'h0000_0000);
      wr(OFS_CTRL, 32'h0000_0001);
      wait_clk(30);
      access(1'b0, OFS_COUNT, 32'h0000_0000);
      check("reset count", 32'(seen <= 32'h0000_0005), 32'h0000_0001);
      rd_chk("reset flag", OFS_FLAGS, 32'h0000_0002);
      wr(OFS_CTRL, 32'h0000_0000);
      wr(OFS_FLAGS, 32'h0000_007F);
      wr(OFS_MACT, 32'h0000_0000);
      $display("test match actions done");
   endtask

   task automatic t_shape();
      int n;
      wr(OFS_COUNT, 32'h0000_0000);
      wr(OFS_PRE_CNT, 32'h0000_0000);
      wr(OFS_PRE_LIM, 32'(lim));
      wr(OFS_MATCH, 32'(per_m));
      wr(OFS_MATCH + 7'h04, 32'(m1));
      wr(OFS_MATCH + 7'h08, 32'(m2));
      wr(OFS_MATCH + 7'h0C, 32'(m3));
      wr(OFS_MATCH + 7'h10, 32'(m4));
      // outputs 1 and 6 single, 2 and 4 double, 3 and 5 disabled
      wr(OFS_OUTCFG, 32'h0000_5614);
      wr(OFS_CTRL, 32'h0000_0005);
      wait_clk(4 * per_clk);
      for (n = 1; n < 5; n = n * 2) begin
         check("period", 32'(load.per_len[n]), 32'(per_clk));
      end
      check("single high", 32'(load.hi_len[1]), 32'((m1 + 1) * (lim + 1)));
      check("positive pulse", 32'(load.hi_len[2]), 32'((m2 - m1) * (lim + 1)));
      check("negative pulse", 32'(load.hi_len[4]), 32'(per_clk - (m3 - m4) * (lim + 1)));
      check("low outputs", 32'(load.hi_len[3] | load.hi_len[5] | load.hi_len[6]), 32'h0000_0000);
      $display("test pulse shape done");
   endtask

   task automatic t_release();
      wr(OFS_MATCH + 7'h04, 32'h0000_0005);
      wait_clk(3 * per_clk);
      check("held value", 32'(load.hi_len[1]), 32'((m1 + 1) * (lim + 1)));
      rd_chk("shadow", OFS_MATCH + 7'h04, 32'h0000_0005);
      wr(OFS_RELEASE, 32'h0000_0002);
      wait_clk(3 * per_clk);
      check("released single", 32'(load.hi_len[1]), 32'(6 * (lim + 1)));
      check("released double", 32'(load.hi_len[2]), 32'((m2 - 5) * (lim + 1)));
      rd_chk("release clear", OFS_RELEASE, 32'h0000_0000);
      $display("test release done");
   endtask

   task automatic t_plain();
      wr(OFS_CTRL, 32'h0000_0001);
      wait_clk(per_clk);
      check("plain outputs", 32'(pwm), 32'h0000_0000);
      rd_chk("plain state", OFS_PWMSTAT, 32'h0000_0000);
      $display("test plain timer done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // clock, reset and main sequence
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      rst             = 1'b1;
      rd_en           = 1'b0;
      wr_en           = 1'b0;
      adr             = 7'h00;
      wdat            = 32'h0000_0000;
      be              = 4'hF;
      cap             = 2'b00;
      n_mismatch      = 0;
      samples_checked = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      wait_clk(2);
      t_reset();
      t_count_mode();
      t_actions();
      t_shape();
      t_release();
      t_plain();
      test_done();
   end

endmodule // match_based_pwm_timer_bench
